// ### verilog/hip_params.svh
/*
  Constants of the hart interrupt pending/enable and wall-clock timer block:
  bit positions, control-register and memory-mapped offsets, reset values.
  Assumes inclusion by bare name from the design files.
*/
// Contract
// R1: CSR writes reach only lower soft/timer pending
// R2: Restricted views show only delegated bits
// R3: Enable bits 11..0 external, timer, software
// R4: Machine timer pending cleared by compare write
// R5: Machine mode may write lower timer pending
// R6: Lower soft pending writable at level or above
// R7: Machine soft pending set only via memory-mapped
// R8: External pending bits driven by controller only
// R9: Non-maskable interrupt never in pending register
// R10: Unsupported levels tie pending and enable zero
// R11: Take interrupt when pending, enabled, globally enabled
// R12: Non-delegated: below machine, or machine global enable
// R13: Delegated: below target, or equal with enable
// R14: Priority external, then software, then timer
// R15: Wall-clock counter is 64-bit, constant rate
// R16: Post timer when count at least compare
// R17: Timer stays pending until compare written
// R18: Timer taken only when enabled and globally on
// R19: Bus writes change one 32-bit half only
// R20: Platform interrupt sources above bit 11
// R21: Delegation bits share pending bit positions
// R22: Pending and enable bits share indices
`ifndef HIP_PARAMS_SVH
`define HIP_PARAMS_SVH

// Bit positions, same in pending, enable and delegation registers
`define HIP_BIT_USOFT 4'h0
`define HIP_BIT_SSOFT 4'h1
`define HIP_BIT_HSOFT 4'h2
`define HIP_BIT_MSOFT 4'h3
`define HIP_BIT_UTIMER 4'h4
`define HIP_BIT_STIMER 4'h5
`define HIP_BIT_HTIMER 4'h6
`define HIP_BIT_MTIMER 4'h7
`define HIP_BIT_UEXT 4'h8
`define HIP_BIT_SEXT 4'h9
`define HIP_BIT_HEXT 4'ha
`define HIP_BIT_MEXT 4'hb
`define HIP_STD_BITS 12

// Control-register selects of the local port
`define HIP_CSR_PENDING 2'h0
`define HIP_CSR_ENABLE 2'h1
`define HIP_CSR_DELEG 2'h2

// Memory-mapped word offsets (byte addresses)
`define HIP_MM_SOFT 5'h00
`define HIP_MM_CMP_LO 5'h08
`define HIP_MM_CMP_HI 5'h0c
`define HIP_MM_CNT_LO 5'h10
`define HIP_MM_CNT_HI 5'h14

// Reset values
`define HIP_CMP_RESET 64'hffff_ffff_ffff_ffff
`define HIP_CNT_RESET 64'h0

`endif

// ### verilog/hip_pkg.sv
/*
  Types of the hart interrupt block: privilege levels and request arbiter states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hip_pkg;
  typedef enum logic [1:0] {
    HIP_PRV_U = 2'h0,
    HIP_PRV_S = 2'h1,
    HIP_PRV_H = 2'h2,
    HIP_PRV_M = 2'h3
  } hip_prv_t;

  typedef enum logic [2:0] {
    HIP_ARB_IDLE = 3'b001,
    HIP_ARB_FIRE = 3'b010,
    HIP_ARB_HOLD = 3'b100
  } hip_arb_t;
endpackage : hip_pkg

// ### verilog/hip_tmr_if.sv
/*
  Carrier between the interrupt block and its wall-clock timer.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
interface hip_tmr_if;
  logic cmp_wr;
  logic cnt_wr;
  logic hi_half;
  logic [31:0] wdata;
  logic [63:0] count;
  logic [63:0] compare;
  logic timer_pending;

  modport ctl (output cmp_wr, output cnt_wr, output hi_half, output wdata,
    input count, input compare, input timer_pending);
  modport tmr (input cmp_wr, input cnt_wr, input hi_half, input wdata,
    output count, output compare, output timer_pending);
endinterface : hip_tmr_if
`default_nettype wire

// ### verilog/hip_timer.sv
/*
  Wall-clock counter and compare register with the machine timer pending flag.
  Assumes a one-cycle tick enable at the timebase rate from the parent.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hip_params.svh"
module hip_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Timebase
  input wire logic tick,
  // Parent side
  hip_tmr_if.tmr tif
);
  logic [63:0] count_r;
  logic [63:0] compare_r;
  logic pending_r;
  logic reached;

  assign reached = (count_r >= compare_r); // R16

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= `HIP_CNT_RESET;
    end else if (tif.cnt_wr) begin
      if (tif.hi_half) count_r[63:32] <= tif.wdata; // R19
      else count_r[31:0] <= tif.wdata;
    end else if (tick) begin
      count_r <= count_r + 64'h1; // R15
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      compare_r <= `HIP_CMP_RESET;
    end else if (tif.cmp_wr) begin
      if (tif.hi_half) compare_r[63:32] <= tif.wdata; // R19
      else compare_r[31:0] <= tif.wdata;
    end
  end

  // Latched once posted; only a compare write drops it, and a fresh match the
  // next cycle re-posts it so a write that leaves the compare behind is safe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pending_r <= 1'b0;
    end else if (tif.cmp_wr) begin
      pending_r <= 1'b0; // R4 R17
    end else if (reached) begin
      pending_r <= 1'b1; // R16
    end
  end

  assign tif.count = count_r;
  assign tif.compare = compare_r;
  assign tif.timer_pending = pending_r;
endmodule : hip_timer
`default_nettype wire

// ### verilog/hip_ctrl.sv
/*
  Per-hart interrupt pending/enable logic with delegation, global enables,
  fixed priority selection and the memory-mapped timer/software registers.
  Assumes the hart core drives the control-register port, the privilege and
  status enables; a platform interrupt controller drives external lines.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hip_params.svh"
module hip_ctrl #(
  parameter logic [3:0] LEVELS_EN = 4'hf,   // Supported levels M,H,S,U (bit3..0)
  parameter int PLAT_BITS = 4,             // Extra platform sources above bit 11
  parameter int TICK_DIV = 100             // Clock cycles per timebase tick
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control-register port
  input wire logic csr_wr,
  input wire logic [1:0] csr_sel,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata,
  // Restricted views of the current lower level
  output logic [31:0] view_pending,
  output logic [31:0] view_enable,
  // Hart state
  input wire hip_pkg::hip_prv_t cur_prv,
  input wire logic [3:0] status_ie,
  // External interrupt lines
  input wire logic [3:0] ext_pending_in,
  input wire logic [PLAT_BITS-1:0] plat_pending_in,
  input wire logic nmi_in,
  // Memory-mapped port
  input wire logic mm_sel,
  input wire logic mm_wr,
  input wire logic [4:0] mm_addr,
  input wire logic [31:0] mm_wdata,
  output logic [31:0] mm_rdata,
  // Interrupt request to the trap logic
  output logic irq_take,
  output logic [3:0] irq_code,
  output hip_pkg::hip_prv_t irq_target,
  output logic nmi_take
);
  localparam int NB = `HIP_STD_BITS + PLAT_BITS;

  hip_tmr_if tif ();

  logic [NB-1:0] enable_r;
  logic [NB-1:0] deleg_r;
  logic [2:0] lsoft_r;
  logic [2:0] ltimer_r;
  logic msoft_r;
  logic [6:0] tick_cnt_r;
  logic tick_r;
  logic [NB-1:0] pending;
  logic [NB-1:0] candidate;
  logic [NB-1:0] gen;
  logic [NB-1:0] level_mask;
  logic [NB-1:0] taken;
  logic [NB-1:0] view_mask;
  logic wr_pend;
  logic wr_en;
  logic wr_deleg;
  logic mm_wr_soft;
  logic m_mode;
  hip_pkg::hip_arb_t arb_r;
  hip_pkg::hip_arb_t arb_nxt;
  logic [3:0] code_nxt;
  logic any_take;
  logic [3:0] code_r;
  hip_pkg::hip_prv_t tgt_r;
  hip_pkg::hip_prv_t tgt_nxt;

  // Timebase divider: one-cycle tick per TICK_DIV clocks
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 7'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 7'(TICK_DIV - 1));
      tick_cnt_r <= (tick_cnt_r == 7'(TICK_DIV - 1)) ? 7'h0 : tick_cnt_r + 7'h1; // R15
    end
  end

  hip_timer u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(tick_r),
    .tif(tif.ctl)
  );

  // Register decode
  assign m_mode = (cur_prv == hip_pkg::HIP_PRV_M);
  assign wr_pend = csr_wr && (csr_sel == `HIP_CSR_PENDING);
  assign wr_en = csr_wr && (csr_sel == `HIP_CSR_ENABLE);
  assign wr_deleg = csr_wr && (csr_sel == `HIP_CSR_DELEG) && m_mode;
  assign mm_wr_soft = mm_sel && mm_wr && (mm_addr == `HIP_MM_SOFT);
  assign tif.cmp_wr = mm_sel && mm_wr && ((mm_addr == `HIP_MM_CMP_LO) || (mm_addr == `HIP_MM_CMP_HI));
  assign tif.cnt_wr = mm_sel && mm_wr && ((mm_addr == `HIP_MM_CNT_LO) || (mm_addr == `HIP_MM_CNT_HI));
  assign tif.hi_half = mm_addr[2]; // R19
  assign tif.wdata = mm_wdata;

  // Lower-level software and timer pending bits, one per level H,S,U
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lower
      logic lvl_ok;
      logic soft_wr_ok;
      assign lvl_ok = LEVELS_EN[g]; // R10
      // Software bit of level g writable from level g or above
      assign soft_wr_ok = wr_pend && (32'(cur_prv) >= 32'(g)); // R6 R1
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          lsoft_r[g] <= 1'b0;
          ltimer_r[g] <= 1'b0;
        end else begin
          if (soft_wr_ok && lvl_ok) lsoft_r[g] <= csr_wdata[g]; // R6
          if (wr_pend && m_mode && lvl_ok) ltimer_r[g] <= csr_wdata[4 + g]; // R5 R1
        end
      end
    end
  endgenerate

  // Machine software pending only through the memory-mapped word
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) msoft_r <= 1'b0;
    else if (mm_wr_soft) msoft_r <= mm_wdata[0]; // R7
  end

  // Level mask: unsupported levels force their three bits to zero
  generate
    for (g = 0; g < NB; g++) begin : g_mask
      if (g < `HIP_STD_BITS) begin : g_std
        assign level_mask[g] = LEVELS_EN[g % 4]; // R10
      end else begin : g_plat
        assign level_mask[g] = 1'b1;
      end
    end
  endgenerate

  // Pending assembly; bit order matches enable and delegation registers
  assign pending[3:0] = {msoft_r, lsoft_r} & level_mask[3:0];
  assign pending[7:4] = {tif.timer_pending, ltimer_r} & level_mask[7:4]; // R4 R22
  assign pending[11:8] = ext_pending_in & level_mask[11:8]; // R8
  assign pending[NB-1:12] = plat_pending_in; // R20
  // The non-maskable request bypasses the pending register entirely
  assign nmi_take = nmi_in; // R9

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      enable_r <= '0;
    end else if (wr_en && m_mode) begin
      enable_r <= csr_wdata[NB-1:0] & level_mask; // R3 R10
    end else if (wr_en) begin
      // Lower levels reach only their delegated bits
      enable_r <= (enable_r & ~view_mask) | (csr_wdata[NB-1:0] & view_mask & level_mask); // R2
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) deleg_r <= '0;
    else if (wr_deleg) deleg_r <= csr_wdata[NB-1:0] & level_mask
      & {{PLAT_BITS{1'b0}}, 12'h777}; // R21
  end

  // Restricted view for the current lower level
  assign view_mask = m_mode ? '0 : deleg_r; // R2
  assign view_pending = 32'(pending & view_mask); // R2
  assign view_enable = 32'(enable_r & view_mask); // R2

  // Global enables per bit
  generate
    for (g = 0; g < NB; g++) begin : g_glob
      logic [1:0] dlvl;
      assign dlvl = (g < `HIP_STD_BITS) ? 2'(g % 4) : 2'h3;
      assign gen[g] = (deleg_r[g] && dlvl != 2'h3)
        ? ((cur_prv < dlvl) || ((cur_prv == dlvl) && status_ie[dlvl])) // R13
        : (!m_mode || status_ie[3]); // R12
    end
  endgenerate

  assign candidate = pending & enable_r; // R22
  assign taken = candidate & gen; // R11 R18

  // Fixed priority: external over software over timer, higher level first
  always_comb begin
    code_nxt = 4'h0;
    any_take = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (!any_take && taken[8 + i]) begin
        code_nxt = 4'(8 + i);
        any_take = 1'b1;
      end
    end
    for (int i = 3; i >= 0; i--) begin
      if (!any_take && taken[i]) begin
        code_nxt = 4'(i);
        any_take = 1'b1;
      end
    end
    for (int i = 3; i >= 0; i--) begin
      if (!any_take && taken[4 + i]) begin
        code_nxt = 4'(4 + i);
        any_take = 1'b1;
      end
    end
    for (int i = NB - 1; i >= `HIP_STD_BITS; i--) begin
      if (!any_take && taken[i]) begin
        code_nxt = 4'hf;
        any_take = 1'b1;
      end
    end
  end // R14

  assign tgt_nxt = (code_nxt < 4'hc && deleg_r[code_nxt])
    ? hip_pkg::hip_prv_t'(code_nxt[1:0]) : hip_pkg::HIP_PRV_M; // R13

  // Request stands while a source is taken and follows the winner each cycle
  always_comb begin
    unique case (arb_r)
      hip_pkg::HIP_ARB_IDLE: arb_nxt = any_take ? hip_pkg::HIP_ARB_FIRE : hip_pkg::HIP_ARB_IDLE;
      hip_pkg::HIP_ARB_FIRE: arb_nxt = any_take ? hip_pkg::HIP_ARB_HOLD : hip_pkg::HIP_ARB_IDLE;
      hip_pkg::HIP_ARB_HOLD: arb_nxt = any_take ? hip_pkg::HIP_ARB_HOLD : hip_pkg::HIP_ARB_IDLE;
      default: arb_nxt = hip_pkg::HIP_ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      arb_r <= hip_pkg::HIP_ARB_IDLE;
      code_r <= 4'h0;
      tgt_r <= hip_pkg::HIP_PRV_M;
    end else begin
      arb_r <= arb_nxt;
      code_r <= code_nxt;
      tgt_r <= tgt_nxt;
    end
  end

  assign irq_take = (arb_r != hip_pkg::HIP_ARB_IDLE); // R11
  assign irq_code = code_r;
  assign irq_target = tgt_r;

  // Read paths; reserved bits of enable read zero
  always_comb begin
    csr_rdata = 32'h0;
    unique case (csr_sel)
      `HIP_CSR_PENDING: csr_rdata = m_mode ? 32'(pending) : view_pending;
      `HIP_CSR_ENABLE: csr_rdata = m_mode ? 32'(enable_r) : view_enable; // R3
      `HIP_CSR_DELEG: csr_rdata = m_mode ? 32'(deleg_r) : 32'h0;
      default: csr_rdata = 32'h0;
    endcase
  end

  always_comb begin
    mm_rdata = 32'h0;
    if (mm_sel) begin
      unique case (mm_addr)
        `HIP_MM_SOFT: mm_rdata = {31'h0, msoft_r};
        `HIP_MM_CMP_LO: mm_rdata = tif.compare[31:0];
        `HIP_MM_CMP_HI: mm_rdata = tif.compare[63:32];
        `HIP_MM_CNT_LO: mm_rdata = tif.count[31:0];
        `HIP_MM_CNT_HI: mm_rdata = tif.count[63:32];
        default: mm_rdata = 32'h0;
      endcase
    end
  end
endmodule : hip_ctrl
`default_nettype wire

// ### tb/hip_ctrl_props.sv
/* Port checker of the hart interrupt block.
   Assumes binding to hip_ctrl; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module hip_ctrl_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [1:0] csr_sel,
  input wire logic [31:0] csr_rdata,
  input wire logic [31:0] view_pending,
  input wire logic [31:0] view_enable,
  // Hart state and lines
  input wire hip_pkg::hip_prv_t cur_prv,
  input wire logic [3:0] status_ie,
  input wire logic [3:0] ext_pending_in,
  input wire logic nmi_in,
  input wire logic mm_sel,
  input wire logic mm_wr,
  // Results
  input wire logic irq_take,
  input wire logic nmi_take
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic m_mode;
  logic pend_m;
  assign m_mode = (cur_prv == hip_pkg::HIP_PRV_M);
  assign pend_m = m_mode && (csr_sel == 2'h0);
  property p_nmi; nmi_take == nmi_in; endproperty
  property p_en_resv; (m_mode && csr_sel == 2'h1) |-> csr_rdata[31:16] == 16'h0; endproperty
  property p_view_m; m_mode |-> (view_pending == 32'h0) && (view_enable == 32'h0); endproperty
  property p_deleg_lo; (!m_mode && csr_sel == 2'h2) |-> csr_rdata == 32'h0; endproperty
  property p_mask; (m_mode && status_ie == 4'h0) [*2] |=> !irq_take; endproperty
  property p_msoft; (pend_m && !(mm_sel && mm_wr)) ##1 pend_m |-> $stable(csr_rdata[3]); endproperty
  // Three quiet cycles cover any settling delay of the external lines
  property p_ext_ro; (pend_m && $stable(ext_pending_in)) [*3] |-> csr_rdata[11:8] == ext_pending_in; endproperty
  property p_mtimer_hold; (pend_m && csr_rdata[7] && !(mm_sel && mm_wr)) ##1 pend_m |-> csr_rdata[7]; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi take differs from line");
  a_en_resv: assert property (p_en_resv) else $error("reserved enable bits set");
  a_view_m: assert property (p_view_m) else $error("restricted view not zero in top mode");
  a_deleg_lo: assert property (p_deleg_lo) else $error("delegation visible below top mode");
  a_mask: assert property (p_mask) else $error("interrupt taken while masked");
  a_msoft: assert property (p_msoft) else $error("machine soft bit changed without bus write");
  a_ext_ro: assert property (p_ext_ro) else $error("external pending bits differ from lines");
  a_mtimer_hold: assert property (p_mtimer_hold) else $error("machine timer bit dropped early");
  c_take: cover property ($rose(irq_take));
  c_mtimer: cover property (pend_m && csr_rdata[7]);
  c_msoft: cover property (pend_m && csr_rdata[3]);
endmodule : hip_ctrl_props
bind hip_ctrl hip_ctrl_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .csr_sel(csr_sel),
  .csr_rdata(csr_rdata), .view_pending(view_pending), .view_enable(view_enable), .cur_prv(cur_prv),
  .status_ie(status_ie), .ext_pending_in(ext_pending_in), .nmi_in(nmi_in), .mm_sel(mm_sel),
  .mm_wr(mm_wr), .irq_take(irq_take), .nmi_take(nmi_take));
`default_nettype wire

// ### tb/hip_plic_model.sv
/* Behavioural platform interrupt controller driving the external lines.
   Assumes the bench raises and drops source requests. */
`timescale 1ns/10ps
`default_nettype none
module hip_plic_model (
  // Clock
  input wire logic clk_sys,
  // Requests from the bench
  input wire logic [3:0] src_req,
  // Lines to the hart
  output logic [3:0] ext_pending_in
);
  initial ext_pending_in = 4'h0;
  // Registered gateway: lines follow requests one cycle late
  always @(posedge clk_sys) begin
    ext_pending_in <= src_req;
  end
endmodule : hip_plic_model
`default_nettype wire

// ### tb/hip_ctrl_test.sv
/* Self-checking bench of the hart interrupt block.
   Assumes the checker bind and the controller model are compiled with it. */
`timescale 1ns/10ps
`default_nettype none
`include "hip_params.svh"
module hip_ctrl_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic csr_wr = 1'b0;
  logic [1:0] csr_sel = 2'h0;
  logic [31:0] csr_wdata = 32'h0;
  logic [31:0] csr_rdata, view_pending, view_enable, mm_rdata;
  hip_pkg::hip_prv_t cur_prv = hip_pkg::HIP_PRV_M;
  hip_pkg::hip_prv_t irq_target;
  logic [3:0] status_ie = 4'h0;
  logic [3:0] src_req = 4'h0;
  logic [3:0] plat_req = 4'h0;
  logic [3:0] ext_pending_in, irq_code;
  logic nmi_in = 1'b0;
  logic mm_sel = 1'b0;
  logic mm_wr = 1'b0;
  logic [4:0] mm_addr = 5'h0;
  logic [31:0] mm_wdata = 32'h0;
  logic irq_take, nmi_take;
  int n_errors = 0;
  int check_count = 0;
  always #5 clk_sys = ~clk_sys;
  hip_plic_model plic (.clk_sys(clk_sys), .src_req(src_req), .ext_pending_in(ext_pending_in));
  // Short timebase so the compare is reached within a few hundred cycles
  hip_ctrl #(.TICK_DIV(2)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .csr_wr(csr_wr), .csr_sel(csr_sel),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .view_pending(view_pending), .view_enable(view_enable),
    .cur_prv(cur_prv), .status_ie(status_ie), .ext_pending_in(ext_pending_in), .plat_pending_in(plat_req),
    .nmi_in(nmi_in), .mm_sel(mm_sel), .mm_wr(mm_wr), .mm_addr(mm_addr), .mm_wdata(mm_wdata),
    .mm_rdata(mm_rdata), .irq_take(irq_take), .irq_code(irq_code), .irq_target(irq_target),
    .nmi_take(nmi_take));
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic cw(input logic [1:0] sel, input logic [31:0] d);
    @(negedge clk_sys);
    csr_wr = 1'b1;
    csr_sel = sel;
    csr_wdata = d;
    @(negedge clk_sys);
    csr_wr = 1'b0;
  endtask : cw
  task automatic cr(input logic [1:0] sel, input logic [31:0] exp, input string nm);
    @(negedge clk_sys);
    csr_sel = sel;
    #1 chk(exp, csr_rdata, nm);
  endtask : cr
  task automatic mw(input logic [4:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    mm_sel = 1'b1;
    mm_wr = 1'b1;
    mm_addr = a;
    mm_wdata = d;
    @(negedge clk_sys);
    mm_sel = 1'b0;
    mm_wr = 1'b0;
  endtask : mw
  task automatic mr(input logic [4:0] a, input logic [31:0] exp, input string nm);
    @(negedge clk_sys);
    mm_sel = 1'b1;
    mm_addr = a;
    #1 chk(exp, mm_rdata, nm);
    mm_sel = 1'b0;
  endtask : mr
  task automatic wirq(input logic [3:0] code, input string nm);
    int i;
    for (i = 0; i < 8 && !(irq_take === 1'b1 && irq_code === code); i++)
      @(negedge clk_sys);
    chk({28'h1, code}, {27'h0, irq_take, irq_code}, nm);
    if (i == 8)
      summarize();
  endtask : wirq
  task automatic t_pending;
    int g;
    cw(2'h0, 32'hffff_ffff);
    cr(2'h0, 32'h77, "pending top write");
    for (g = 0; g < 3; g++) begin
      cw(2'h0, 32'h0);
      cur_prv = hip_pkg::hip_prv_t'(g);
      cw(2'h0, 32'hff);
      cur_prv = hip_pkg::HIP_PRV_M;
      cr(2'h0, (32'h2 << g) - 32'h1, "pending lower write");
    end
  endtask : t_pending
  task automatic t_deleg;
    cw(2'h2, 32'hffff_ffff);
    cr(2'h2, 32'h777, "deleg");
    cw(2'h2, 32'h20);
    cw(2'h1, 32'h0);
    cw(2'h0, 32'h77);
    cur_prv = hip_pkg::HIP_PRV_S;
    cw(2'h1, 32'hfff);
    cr(2'h0, 32'h20, "view pending read");
    chk(32'h20, view_pending, "view pending");
    cr(2'h1, 32'h20, "view enable read");
    chk(32'h20, view_enable, "view enable");
    cur_prv = hip_pkg::HIP_PRV_M;
    cr(2'h1, 32'h20, "enable from lower");
    cw(2'h2, 32'h0);
    cw(2'h1, 32'hffff_ffff);
    // Platform enables above bit 11 are writable too
    cr(2'h1, 32'hffff, "enable all");
  endtask : t_deleg
  task automatic t_irq;
    cw(2'h0, 32'h77);
    src_req = 4'hf;
    repeat (4) @(negedge clk_sys);
    chk(32'h0, {31'h0, irq_take}, "masked take");
    status_ie = 4'h8;
    wirq(4'hb, "ext top");
    chk(32'h3, {30'h0, irq_target}, "target");
    src_req = 4'h7;
    wirq(4'ha, "ext hyper");
    src_req = 4'h0;
    wirq(4'h2, "soft hyper");
    cw(2'h0, 32'h70);
    wirq(4'h6, "timer hyper");
    status_ie = 4'h0;
    cur_prv = hip_pkg::HIP_PRV_U;
    repeat (3) @(negedge clk_sys);
    wirq(4'h6, "lower mode take");
    cur_prv = hip_pkg::HIP_PRV_M;
    cw(2'h0, 32'h0);
    repeat (3) @(negedge clk_sys);
    chk(32'h0, {31'h0, irq_take}, "take off");
  endtask : t_irq
  task automatic t_msoft;
    mw(`HIP_MM_SOFT, 32'h1);
    cr(2'h0, 32'h8, "soft top set");
    cw(2'h0, 32'h0);
    cr(2'h0, 32'h8, "soft top by csr");
    mw(`HIP_MM_SOFT, 32'h0);
    cr(2'h0, 32'h0, "soft top clear");
    mr(5'h1c, 32'h0, "unmapped");
    nmi_in = 1'b1;
    cr(2'h0, 32'h0, "nmi hidden");
    chk(32'h1, {31'h0, nmi_take}, "nmi take");
    nmi_in = 1'b0;
  endtask : t_msoft
  task automatic t_dirq;
    cw(2'h2, 32'h20);
    cw(2'h0, 32'h20);
    cur_prv = hip_pkg::HIP_PRV_S;
    repeat (3) @(negedge clk_sys);
    chk(32'h0, {31'h0, irq_take}, "delegated masked");
    status_ie = 4'h2;
    wirq(4'h5, "delegated take");
    chk(32'h1, {30'h0, irq_target}, "delegated target");
    status_ie = 4'h0;
    cur_prv = hip_pkg::HIP_PRV_U;
    repeat (3) @(negedge clk_sys);
    wirq(4'h5, "delegated from below");
    cur_prv = hip_pkg::HIP_PRV_M;
    repeat (3) @(negedge clk_sys);
    chk(32'h0, {31'h0, irq_take}, "delegated above");
    status_ie = 4'h8;
    plat_req = 4'h1;
    wirq(4'hf, "platform take");
    chk(32'h3, {30'h0, irq_target}, "platform target");
    plat_req = 4'h0;
    status_ie = 4'h0;
    cw(2'h2, 32'h0);
    cw(2'h0, 32'h0);
  endtask : t_dirq
  task automatic t_timer;
    int i;
    mw(`HIP_MM_CNT_LO, 32'h0);
    mw(`HIP_MM_CNT_HI, 32'h0);
    mw(`HIP_MM_CMP_HI, 32'h0);
    mw(`HIP_MM_CMP_LO, 32'h40);
    mr(`HIP_MM_CMP_HI, 32'h0, "compare high");
    cr(2'h0, 32'h0, "timer early");
    for (i = 0; i < 300 && csr_rdata[7] !== 1'b1; i++)
      @(negedge clk_sys);
    mm_sel = 1'b1;
    mm_addr = `HIP_MM_CNT_LO;
    #1 chk(32'h1, {31'h0, mm_rdata >= 32'h40 && mm_rdata < 32'h43}, "count at post");
    mm_sel = 1'b0;
    cr(2'h0, 32'h80, "timer posted");
    if (i == 300) begin
      n_errors++;
      $display("unexpected timer post wait: expected post within 300 cycles, seen none");
      summarize();
    end
    status_ie = 4'h8;
    wirq(4'h7, "timer top take");
    status_ie = 4'h0;
    repeat (20) @(negedge clk_sys);
    cw(2'h0, 32'h0);
    cr(2'h0, 32'h80, "timer held");
    mw(`HIP_MM_CMP_HI, 32'h1);
    cr(2'h0, 32'h0, "timer cleared");
    mr(`HIP_MM_CMP_LO, 32'h40, "compare low kept");
  endtask : t_timer
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    cr(2'h0, 32'h0, "pending reset");
    cr(2'h1, 32'h0, "enable reset");
    mr(`HIP_MM_CMP_LO, 32'hffff_ffff, "compare reset");
    t_pending();
    t_deleg();
    t_irq();
    t_msoft();
    t_dirq();
    t_timer();
    summarize();
  end
endmodule : hip_ctrl_test
`default_nettype wire
